//--- osc_pkg.sv
`default_nettype none
package osc_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] ctrl_ofs = 8'h00;
    localparam logic [7:0] trim_pri_ofs = 8'h04;
    localparam logic [7:0] trim_seq_ofs = 8'h08;
    localparam logic [7:0] cfg_ofs = 8'h0c;
    // Control register fields
    localparam int go_bit = 0;
    localparam int fail_bit = 3;
    localparam int seq_en_bit = 4;
    localparam int dith_en_bit = 5;
    localparam int new_lsb = 8;
    localparam int cur_lsb = 12;
    // Configuration register fields
    localparam int mode_lsb = 0;
    localparam int group_lsb = 2;
    localparam int range_bit = 4;
    localparam int swcfg_lsb = 6;
    // Reset values
    localparam logic [1:0] swcfg_rst = 2'h3;
    localparam logic [1:0] group_rst = 2'h0;
    localparam logic [1:0] mode_rst = 2'h3;
    localparam logic [14:0] lfsr_seed = 15'h0001;
    // Source selections (group in bit 1)
    localparam logic [2:0] sel_rc = 3'h0;
    localparam logic [2:0] sel_pri = 3'h2;
    // Primary oscillator modes
    localparam logic [1:0] mode_ext = 2'h0;
    localparam logic [1:0] mode_xtal = 2'h2;
    localparam logic [1:0] mode_off = 2'h3;
    // Switch and monitor settings
    localparam logic [1:0] swcfg_both = 2'h0;
    // Roll counter field feeding the sequencer
    localparam int roll_hi = 5;
    localparam int roll_lo = 3;
    // Switch sequencer states
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_switch = 2'b10
    } sw_state_e;
endpackage : osc_pkg
`default_nettype wire

//--- rc_osc_trim_dither_fail_monitor.sv
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - RC oscillator powered unless primary selected in external/crystal mode
// - Also powered after detected failure with monitor
// - Two ranges, low and high, via range_select
// - range_select 0 low, 1 high
// - 4-bit trim from primary or sequence registers
// - Sequence and dither off: only trim_field applies
// - Sequencing uses 8-input 4-bit multiplexer
// - Multiplexer select is wrap count bits 5:3
// - 15-bit LFSR low four bits give trim
// - Dither applies only while dither_enable set
// - LFSR steps when wrap count bit3 toggles
// - Config 1x disables switching and monitor
// - 00 enables both; 01 switching only
// - Failure raises trap, moves clock to RC
// - Failure loads RC select, sets flag, clears go
// - Slow start traps, selects RC, stops oscillator
// - Failure leaves low-power RC clock running
// - Switch only between groups; group fixes choice
// - Switching off: config selects, status reflects
module rc_osc_trim_dither_fail_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // PWM and oscillator status
    input wire logic [5:0] pwm_period_wrap_count,
    input wire logic osc_fail,
    input wire logic slow_start_timeout,
    // Oscillator controls
    output logic fast_rc_osc_power,
    output logic fast_rc_osc_range,
    output logic [3:0] fast_rc_osc_trim,
    output logic [2:0] sys_clk_source,
    output logic primary_osc_enable,
    output logic low_power_rc_run,
    output logic clock_fail_trap
);
    import osc_pkg::*;

    // Byte-lane merge for the 16-bit registers
    // Lanes 2 and 3 are ignored; registers are 16 bits wide
    function automatic logic [15:0] merge(input logic [15:0] old,
            input logic [31:0] d, input logic [3:0] sel);
        merge = old;
        if (sel[0]) begin
            merge[7:0] = d[7:0];
        end
        if (sel[1]) begin
            merge[15:8] = d[15:8];
        end
    endfunction : merge

    // Software-visible state
    logic osc_switch_go;
    logic clock_fail_flag;
    logic sequence_enable;
    logic dither_enable;
    logic [2:0] new_osc_select;
    logic [2:0] current_osc_select;
    logic [15:0] trim_reg_primary;
    logic [15:0] trim_reg_sequence;
    logic [1:0] primary_osc_mode;
    logic [1:0] initial_osc_group;
    logic range_select;
    logic [1:0] switch_monitor_cfg;
    // Internal state
    sw_state_e state;
    logic [14:0] lfsr;
    logic roll3_q;
    logic pri_stopped;

    // Bus decode
    // A write commits only at the ack edge, once per cycle
    wire req = wb_cyc & wb_stb;
    wire wr = req & wb_we & wb_ack;
    wire hit_ctrl = wb_adr == ctrl_ofs;
    wire hit_pri = wb_adr == trim_pri_ofs;
    wire hit_seq = wb_adr == trim_seq_ofs;
    wire hit_cfg = wb_adr == cfg_ofs;
    // Read-back images; unused bits read as zero
    wire [15:0] ctrl_word = {1'b0, current_osc_select, 1'b0,
        new_osc_select, 2'b00, dither_enable, sequence_enable,
        clock_fail_flag, 2'b00, osc_switch_go};
    wire [15:0] cfg_word = {8'h00, switch_monitor_cfg, 1'b0,
        range_select, initial_osc_group, primary_osc_mode};
    // Merged write images keep lanes that sel leaves out
    wire [15:0] ctrl_new = merge(ctrl_word, wb_dat_w, wb_sel);
    wire [15:0] cfg_new = merge(cfg_word, wb_dat_w, wb_sel);
    // Unmapped offsets read as zero
    wire [15:0] rd_mux = hit_ctrl ? ctrl_word :
        hit_pri ? trim_reg_primary :
        hit_seq ? trim_reg_sequence :
        hit_cfg ? cfg_word : 16'h0000;

    // Switch and monitor enables from the configuration
    // Config 1x: both off; 01: switching only; 00: both on
    wire switch_en = ~switch_monitor_cfg[1];
    wire monitor_en = switch_monitor_cfg == swcfg_both;

    // Failure event: only matters while running a primary source
    // A held failure input keeps trapping only while on primary
    wire on_primary = current_osc_select[1];
    wire fail_evt = monitor_en & on_primary &
        (osc_fail | slow_start_timeout);

    // Group switch target; choice in a group is fixed by config
    wire [2:0] grp_pri = initial_osc_group[1] ?
        {1'b0, initial_osc_group} : sel_pri;
    wire [2:0] grp_rc = initial_osc_group[1] ?
        sel_rc : {1'b0, initial_osc_group};
    // Target group comes from new_osc_select bit 1
    wire [2:0] switch_target = new_osc_select[1] ? grp_pri : grp_rc;

    // Sequencer slots: slot 0 is trim_field
    // Slot n is nibble n across the two trim registers
    wire [2:0] slot_idx = pwm_period_wrap_count[roll_hi:roll_lo];
    wire [31:0] slots = {trim_reg_sequence, trim_reg_primary};
    wire [3:0] seq_trim = slots[{slot_idx, 2'b00} +: 4];
    // Source priority: dither, then sequence, then trim_field
    wire [3:0] next_trim = dither_enable ? lfsr[3:0] :
        sequence_enable ? seq_trim :
        trim_reg_primary[3:0];

    // Dither step on each toggle of wrap count bit 3
    wire roll3 = pwm_period_wrap_count[roll_lo];
    // Previous sample of bit 3 turns any change into one step
    wire lfsr_step = roll3 ^ roll3_q;
    // Taps x^15 + x^14 + 1 give the maximal 32767 sequence
    wire lfsr_fb = lfsr[14] ^ lfsr[13];

    // Power and clock outputs
    // RC stays powered off primary or after a monitored failure
    wire pri_mode_on = primary_osc_mode == mode_ext ||
        primary_osc_mode == mode_xtal;
    wire next_power = ~pri_mode_on | ~on_primary |
        (monitor_en & clock_fail_flag);
    // A stopped primary stays off until software switches back or turns switching off
    wire next_pri_en = primary_osc_mode != mode_off & ~pri_stopped;

    // Bus slave: one wait state, answer for any address
    // Ack drops after one cycle even if the master holds req
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack <= req & ~wb_ack;
            if (req & ~wb_ack) begin
                wb_dat_r <= {16'h0000, rd_mux};
            end
        end
    end

    // Trim and configuration registers
    // Software may rewrite the configuration at any time
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trim_reg_primary <= 16'h0000;
            trim_reg_sequence <= 16'h0000;
            switch_monitor_cfg <= swcfg_rst;
            initial_osc_group <= group_rst;
            primary_osc_mode <= mode_rst;
            range_select <= 1'b0;
        end else if (wr) begin
            if (hit_pri) begin
                trim_reg_primary <= merge(trim_reg_primary, wb_dat_w,
                    wb_sel);
            end
            if (hit_seq) begin
                trim_reg_sequence <= merge(trim_reg_sequence, wb_dat_w,
                    wb_sel);
            end
            if (hit_cfg) begin
                primary_osc_mode <= cfg_new[mode_lsb +: 2];
                initial_osc_group <= cfg_new[group_lsb +: 2];
                range_select <= cfg_new[range_bit];
                switch_monitor_cfg <= cfg_new[swcfg_lsb +: 2];
            end
        end
    end

    // Control register bits written by software
    // The go bit lives in the switch sequencer below
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sequence_enable <= 1'b0;
            dither_enable <= 1'b0;
            new_osc_select <= sel_rc;
        end else if (wr & hit_ctrl) begin
            sequence_enable <= ctrl_new[seq_en_bit];
            dither_enable <= ctrl_new[dith_en_bit];
            new_osc_select <= ctrl_new[new_lsb +: 3];
        end
    end

    // Fail flag: a failure wins over a software clear
    // Software clears it by writing zero to the flag bit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clock_fail_flag <= 1'b0;
        end else if (fail_evt) begin
            clock_fail_flag <= 1'b1;
        end else if (wr & hit_ctrl) begin
            clock_fail_flag <= ctrl_new[fail_bit];
        end
    end

    // Switch sequencer and current source
    // Go written at edge E: state moves at E+1, source at E+2
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= st_idle;
            osc_switch_go <= 1'b0;
            current_osc_select <= sel_rc;
            pri_stopped <= 1'b0;
        end else if (!switch_en) begin
            // Config drives the source; status only mirrors it
            state <= st_idle;
            osc_switch_go <= 1'b0;
            current_osc_select <= {1'b0, initial_osc_group};
            pri_stopped <= 1'b0;
        end else if (fail_evt) begin
            // Fall back to RC and drop the failing oscillator
            state <= st_idle;
            osc_switch_go <= 1'b0;
            current_osc_select <= sel_rc;
            pri_stopped <= 1'b1;
        end else begin
            case (state)
                st_idle: begin
                    if (wr & hit_ctrl) begin
                        osc_switch_go <= ctrl_new[go_bit];
                    end
                    if (osc_switch_go) begin
                        state <= st_switch;
                    end
                end
                st_switch: begin
                    // Completed switch self-clears the request
                    current_osc_select <= switch_target;
                    pri_stopped <= ~switch_target[1];
                    osc_switch_go <= 1'b0;
                    state <= st_idle;
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Dither shift register
    // Reset tracks bit 3 so a high level gives no false step
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lfsr <= lfsr_seed;
            roll3_q <= roll3;
        end else begin
            roll3_q <= roll3;
            if (lfsr_step) begin
                lfsr <= {lfsr[13:0], lfsr_fb};
            end
        end
    end

    // Registered oscillator outputs
    // Every output leaves the block straight from a flip-flop
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_rc_osc_power <= 1'b1;
            fast_rc_osc_range <= 1'b0;
            fast_rc_osc_trim <= 4'h0;
            sys_clk_source <= sel_rc;
            primary_osc_enable <= 1'b0;
            low_power_rc_run <= 1'b1;
            clock_fail_trap <= 1'b0;
        end else begin
            fast_rc_osc_power <= next_power;
            fast_rc_osc_range <= range_select;
            fast_rc_osc_trim <= next_trim;
            sys_clk_source <= current_osc_select;
            primary_osc_enable <= next_pri_en;
            // Watchdog clock never depends on the monitor
            low_power_rc_run <= 1'b1;
            clock_fail_trap <= fail_evt;
        end
    end
endmodule : rc_osc_trim_dither_fail_monitor
`default_nettype wire

//--- rc_osc_trim_dither_fail_monitor_sva.sv
`timescale 1ns/1ps
`default_nettype none
module osc_mon_chk
    import osc_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic wb_ack,
    // Oscillator side
    input wire logic osc_fail,
    input wire logic slow_start_timeout,
    input wire logic fast_rc_osc_power,
    input wire logic [2:0] sys_clk_source,
    input wire logic primary_osc_enable,
    input wire logic low_power_rc_run,
    input wire logic clock_fail_trap
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Either failure cause
    wire logic fail_in = osc_fail | slow_start_timeout;
    // Shadow of the monitor setting; lands at the ack edge
    logic [1:0] swcfg;
    always_ff @(posedge clk) begin
        if (sys_rst)
            swcfg <= swcfg_rst;
        else if (wb_ack && wb_we && wb_sel[0] && wb_adr == cfg_ofs)
            swcfg <= wb_dat_w[swcfg_lsb +: 2];
    end
    ack_answer_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack |=> !wb_ack)
        else $error("ack held too long");
    low_power_rc_clock_run_a: assert property (low_power_rc_run)
        else $error("low-power clock stopped");
    trap_cause_a: assert property (
        clock_fail_trap |-> $past(fail_in) || $past(fail_in, 2))
        else $error("trap without failure");
    trap_to_rc_a: assert property (
        clock_fail_trap |-> ##[0:2] sys_clk_source == sel_rc)
        else $error("trap left clock on primary");
    trap_stop_a: assert property (
        clock_fail_trap |-> ##[0:2] !primary_osc_enable)
        else $error("primary still enabled after trap");
    // Two cycles on the RC group give the registered power time to follow
    rc_power_a: assert property (
        !sys_clk_source[1] && !$past(sys_clk_source[1]) |-> fast_rc_osc_power)
        else $error("rc oscillator unpowered while selected");
    mon_off_a: assert property (
        swcfg != swcfg_both && $past(swcfg) != swcfg_both
        && $past(swcfg, 2) != swcfg_both |-> !clock_fail_trap)
        else $error("trap while monitor disabled");
endmodule : osc_mon_chk
`default_nettype wire

//--- rc_osc_trim_dither_fail_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rc_osc_trim_dither_fail_monitor_tb;
    import osc_pkg::*;
    // Stimulus, idle at time zero
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h3;
    logic [31:0] wb_dat_w = 32'h0;
    logic [5:0] pwm_period_wrap_count = 6'h00;
    logic osc_fail = 1'b0;
    logic slow_start_timeout = 1'b0;
    // Observed outputs
    logic [31:0] wb_dat_r;
    logic [3:0] fast_rc_osc_trim;
    logic [2:0] sys_clk_source;
    logic wb_ack, fast_rc_osc_power, fast_rc_osc_range;
    logic primary_osc_enable, low_power_rc_run, clock_fail_trap;
    // Counters, read data and dither model
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [14:0] lfsr;

    always #20 clk = ~clk;

    rc_osc_trim_dither_fail_monitor dut (.clk, .sys_rst, .wb_cyc, .wb_stb,
        .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack,
        .pwm_period_wrap_count, .osc_fail, .slow_start_timeout,
        .fast_rc_osc_power, .fast_rc_osc_range, .fast_rc_osc_trim,
        .sys_clk_source, .primary_osc_enable, .low_power_rc_run,
        .clock_fail_trap);

    task automatic chk(input string nm, input logic [31:0] got,
            input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // Classic cycle; a lost ack ends the run
    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d);
        int i;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'h3;
        wb_adr <= a;
        wb_dat_w <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wb_ack !== 1'b1 && i < 16);
        if (wb_ack !== 1'b1) begin
            chk("ack", 0, 1);
            results();
        end
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    // One-cycle failure, then count trap pulses
    task automatic fail_pulse(input logic slow, output int n);
        @(posedge clk);
        osc_fail <= !slow;
        slow_start_timeout <= slow;
        @(posedge clk);
        osc_fail <= 1'b0;
        slow_start_timeout <= 1'b0;
        n = 0;
        repeat (6) begin
            @(posedge clk);
            n += int'(clock_fail_trap === 1'b1);
        end
    endtask : fail_pulse

    task automatic reset_run;
        chk("power", fast_rc_osc_power, 1);
        chk("trim", fast_rc_osc_trim, 0);
        chk("source", sys_clk_source, sel_rc);
        chk("low_power_rc_clock", low_power_rc_run, 1);
        wb(0, cfg_ofs, 0);
        chk("cfg", rd, {24'h0, swcfg_rst, 2'h0, group_rst, mode_rst});
        wb(0, 8'h10, 0);
        chk("unmapped", rd, 0);
        wb(1, cfg_ofs, 32'hd3);
        repeat (2) @(posedge clk);
        chk("range", fast_rc_osc_range, 1);
    endtask : reset_run

    // Dither beats sequencing; LFSR steps only on bit 3 changes
    task automatic dither_run;
        logic [5:0] w;
        wb(1, trim_pri_ofs, 32'h4321);
        wb(1, trim_seq_ofs, 32'h8765);
        pwm_period_wrap_count <= 6'h10;
        repeat (3) @(posedge clk);
        chk("trim only", fast_rc_osc_trim, 1);
        wb(1, ctrl_ofs, 32'h30);
        lfsr = lfsr_seed;
        // One wrap per step: bit 3 toggles once in every 8 steps
        repeat (136) begin
            w = pwm_period_wrap_count + 6'h01;
            if (w[3] != pwm_period_wrap_count[3])
                lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
            pwm_period_wrap_count <= w;
            repeat (3) @(posedge clk);
            chk("dither", fast_rc_osc_trim, lfsr[3:0]);
        end
        wb(1, ctrl_ofs, 0);
        repeat (2) @(posedge clk);
        chk("dither off", fast_rc_osc_trim, 1);
    endtask : dither_run

    // Wrap count climbs by one; only bits 5:3 pick the slot
    task automatic sequence_run;
        logic [5:0] c;
        wb(1, ctrl_ofs, 32'h10);
        c = pwm_period_wrap_count;
        repeat (64) begin
            c = c + 6'h01;
            pwm_period_wrap_count <= c;
            repeat (3) @(posedge clk);
            chk("slot", fast_rc_osc_trim, {1'b0, c[5:3]} + 4'h1);
        end
    endtask : sequence_run

    task automatic fail_run;
        int n;
        wb(1, cfg_ofs, 32'h0a);
        // Switch only to a full-rate primary while monitored
        wb(1, ctrl_ofs, 32'h0201);
        repeat (5) @(posedge clk);
        chk("to primary", sys_clk_source, sel_pri);
        chk("xtal power", fast_rc_osc_power, 0);
        chk("range low", fast_rc_osc_range, 0);
        chk("pri run", primary_osc_enable, 1);
        fail_pulse(0, n);
        chk("traps", n, 1);
        chk("fail source", sys_clk_source, sel_rc);
        chk("fail power", fast_rc_osc_power, 1);
        chk("low_power_rc_clock kept", low_power_rc_run, 1);
        wb(0, ctrl_ofs, 0);
        chk("status", rd & 32'h7009, 32'h0008);
        wb(1, ctrl_ofs, 32'h0201);
        repeat (5) @(posedge clk);
        fail_pulse(1, n);
        chk("slow traps", n, 1);
        chk("slow stop", primary_osc_enable, 0);
    endtask : fail_run

    task automatic disabled_run;
        int n;
        wb(1, cfg_ofs, 32'h4a);
        wb(1, ctrl_ofs, 32'h0201);
        repeat (5) @(posedge clk);
        chk("switched", sys_clk_source, sel_pri);
        fail_pulse(0, n);
        chk("switch only", n, 0);
        wb(1, cfg_ofs, 32'hc2);
        repeat (3) @(posedge clk);
        chk("fixed rc", sys_clk_source, sel_rc);
        wb(1, cfg_ofs, 32'hc8);
        wb(1, ctrl_ofs, 32'h0001);
        repeat (5) @(posedge clk);
        chk("fixed pri", sys_clk_source, sel_pri);
        chk("ext power", fast_rc_osc_power, 0);
        fail_pulse(0, n);
        chk("monitor off", n, 0);
    endtask : disabled_run

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        reset_run();
        dither_run();
        sequence_run();
        fail_run();
        disabled_run();
        // Second reset in mid-run must restore every default
        sys_rst <= 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        reset_run();
        results();
    end
endmodule : rc_osc_trim_dither_fail_monitor_tb

bind rc_osc_trim_dither_fail_monitor osc_mon_chk chk (.clk, .sys_rst,
    .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_ack,
    .osc_fail,
    .slow_start_timeout, .fast_rc_osc_power, .sys_clk_source,
    .primary_osc_enable, .low_power_rc_run, .clock_fail_trap);
`default_nettype wire
